// ===== core/rhm_mode_ctrl.sv
// rhm_mode_ctrl: run/halt button, run/stop switch and start-up selection
//
// What this block does
// - Release at start-up runs pattern's action
// - Release on green 1 Hz: boot wait
// - Release on red 4 Hz: erase, keep backup
// - That erase loads clock with 1990-01-01 midnight
// - Release on red 2 Hz: stop mode
// - Release on red/green: erase all, backup too
// - Full erase skips card-to-flash copy
// - Press 0.5 to 3 s toggles run/halt
// - Press over 3 s reloads saved program
// - Switch to stop: run becomes stop
// - Switch to run: cold start
// - Switch ignored unless enabled by configuration
`timescale 1ns/1ps
module rhm_mode_ctrl #(
	parameter int CYC_PER_MS = rhm_pkg::CYC_PER_MS
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic button_pressed,
	input wire logic switch_run,
	input wire logic switch_enable,
	output rhm_pkg::rhm_mode_t mode_o,
	output rhm_pkg::rhm_led_t led_o,
	output rhm_pkg::rhm_action_t action_o,
	output rhm_pkg::rhm_rtc_t rtc_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// pattern that follows a given one, wrapping to the first
	function automatic rhm_pkg::rhm_pat_t next_pat(input rhm_pkg::rhm_pat_t p);
		case (p)
			rhm_pkg::PAT_ORANGE: next_pat = rhm_pkg::PAT_GREEN1;
			rhm_pkg::PAT_GREEN1: next_pat = rhm_pkg::PAT_RED4;
			rhm_pkg::PAT_RED4: next_pat = rhm_pkg::PAT_RED2;
			rhm_pkg::PAT_RED2: next_pat = rhm_pkg::PAT_REDGREEN;
			default: next_pat = rhm_pkg::PAT_ORANGE;
		endcase
	endfunction

	// last millisecond of a blink half period for a pattern
	function automatic logic [rhm_pkg::MS_W-1:0] blink_last(input rhm_pkg::rhm_pat_t p);
		case (p)
			rhm_pkg::PAT_GREEN1: blink_last = rhm_pkg::BLINK1_LAST;
			rhm_pkg::PAT_RED4: blink_last = rhm_pkg::BLINK4_LAST;
			default: blink_last = rhm_pkg::BLINK2_LAST;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state and wires

	localparam logic [rhm_pkg::MS_W-1:0] MS_ONE = 12'h001;

	// controller state
	rhm_pkg::rhm_state_t state_reg;
	rhm_pkg::rhm_state_t state_next;
	// start-up pattern on show
	rhm_pkg::rhm_pat_t pat_reg;
	rhm_pkg::rhm_pat_t pat_next;
	// action pulses
	rhm_pkg::rhm_action_t action_reg;
	rhm_pkg::rhm_action_t action_next;
	// led drive
	rhm_pkg::rhm_led_t led_reg;
	rhm_pkg::rhm_led_t led_next;
	// clock preset output
	rhm_pkg::rhm_rtc_t rtc_reg;
	// previous input levels for edge detection
	logic btn_prev_reg;
	logic sw_prev_reg;
	// press length in milliseconds, saturating
	logic [rhm_pkg::MS_W-1:0] press_ms_reg;
	logic [rhm_pkg::MS_W-1:0] press_ms_next;
	// time on the current pattern
	logic [rhm_pkg::MS_W-1:0] step_ms_reg;
	logic [rhm_pkg::MS_W-1:0] step_ms_next;
	// time in the current blink half period
	logic [rhm_pkg::MS_W-1:0] blink_ms_reg;
	logic [rhm_pkg::MS_W-1:0] blink_ms_next;
	// blink phase, high shows the lit half
	logic blink_ph_reg;
	logic blink_ph_next;
	// millisecond tick
	logic ms_tick;

	// decoded events
	logic release_evt;
	logic sw_rise;
	logic sw_fall;
	logic in_op;
	logic in_start;
	logic press_toggle;
	logic press_reload;
	logic step_done;
	logic blink_done;
	logic pat_change;

	// millisecond time base
	rhm_ms_tick #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_tick (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.ms_tick(ms_tick)
	);

	// button let go on this enabled edge
	assign release_evt = clk_en & btn_prev_reg & ~button_pressed;
	assign sw_rise = clk_en & switch_enable & ~sw_prev_reg & switch_run;
	assign sw_fall = clk_en & switch_enable & sw_prev_reg & ~switch_run;
	assign in_op = (state_reg == rhm_pkg::ST_RUN) || (state_reg == rhm_pkg::ST_HALT)
		|| (state_reg == rhm_pkg::ST_STOP);
	assign in_start = (state_reg == rhm_pkg::ST_STARTUP);
	assign press_toggle = (press_ms_reg > rhm_pkg::HALF_MS) && (press_ms_reg < rhm_pkg::LONG_MS);
	assign press_reload = (press_ms_reg > rhm_pkg::LONG_MS);
	assign step_done = in_start & ms_tick & (step_ms_reg == rhm_pkg::STEP_LAST);
	assign blink_done = in_start & ms_tick & (blink_ms_reg == blink_last(pat_reg));
	assign pat_change = (pat_next != pat_reg);

	////////////////////////////////////////////////////////////////////////
	// counters

	// press length counts only while held in operation
	assign press_ms_next = (!in_op || !button_pressed) ? '0 :
		(ms_tick && press_ms_reg != rhm_pkg::LONG_SAT) ? press_ms_reg + MS_ONE : press_ms_reg;
	assign step_ms_next = (!in_start || step_done) ? '0 :
		ms_tick ? step_ms_reg + MS_ONE : step_ms_reg;
	// each new pattern starts at the lit half of its blink
	assign blink_ms_next = (!in_start || pat_change || blink_done) ? '0 :
		ms_tick ? blink_ms_reg + MS_ONE : blink_ms_reg;
	assign blink_ph_next = (!in_start || pat_change) ? 1'b1 :
		blink_done ? ~blink_ph_reg : blink_ph_reg;

	////////////////////////////////////////////////////////////////////////
	// next state and actions

	always_comb begin
		state_next = state_reg;
		pat_next = pat_reg;
		action_next = '0;
		case (state_reg)
			// button level at power-up selects the start-up path
			rhm_pkg::ST_INIT: begin
				pat_next = rhm_pkg::PAT_ORANGE;
				state_next = button_pressed ? rhm_pkg::ST_STARTUP : rhm_pkg::ST_RUN;
			end
			rhm_pkg::ST_STARTUP: begin
				if (release_evt) begin
					case (pat_reg)
						rhm_pkg::PAT_GREEN1: state_next = rhm_pkg::ST_BOOT;
						rhm_pkg::PAT_RED4: begin
							state_next = rhm_pkg::ST_RUN;
							action_next.erase_media = 1'b1;
							action_next.rtc_load = 1'b1;
						end
						rhm_pkg::PAT_RED2: state_next = rhm_pkg::ST_STOP;
						rhm_pkg::PAT_REDGREEN: begin
							state_next = rhm_pkg::ST_RUN;
							action_next.erase_media = 1'b1;
							action_next.erase_flash_backup = 1'b1;
							action_next.skip_card_copy = 1'b1;
						end
						default: state_next = rhm_pkg::ST_RUN;
					endcase
				end else if (step_done) begin
					pat_next = next_pat(pat_reg);
				end
			end
			// firmware download wait, left only by reset
			rhm_pkg::ST_BOOT: state_next = rhm_pkg::ST_BOOT;
			rhm_pkg::ST_RUN, rhm_pkg::ST_HALT, rhm_pkg::ST_STOP: begin
				if (sw_fall && state_reg == rhm_pkg::ST_RUN) begin
					state_next = rhm_pkg::ST_STOP;
				end else if (sw_rise) begin
					state_next = rhm_pkg::ST_RUN;
					action_next.cold_start = 1'b1;
				end else if (release_evt && press_toggle) begin
					state_next = (state_reg == rhm_pkg::ST_RUN) ? rhm_pkg::ST_HALT
						: rhm_pkg::ST_RUN;
				end else if (release_evt && press_reload) begin
					action_next.reload_prog = 1'b1;
				end
			end
			default: state_next = rhm_pkg::ST_INIT;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// led decode

	always_comb begin
		led_next = '0;
		case (state_next)
			rhm_pkg::ST_STARTUP: begin
				case (pat_next)
					rhm_pkg::PAT_GREEN1: led_next = '{red: 1'b0, green: blink_ph_next};
					rhm_pkg::PAT_RED4: led_next = '{red: blink_ph_next, green: 1'b0};
					rhm_pkg::PAT_RED2: led_next = '{red: blink_ph_next, green: 1'b0};
					rhm_pkg::PAT_REDGREEN: led_next = '{red: blink_ph_next, green: ~blink_ph_next};
					// orange is both lit
					default: led_next = '{red: 1'b1, green: 1'b1};
				endcase
			end
			rhm_pkg::ST_RUN: led_next = '{red: 1'b0, green: 1'b1};
			rhm_pkg::ST_HALT: led_next = '{red: 1'b1, green: 1'b1};
			rhm_pkg::ST_STOP: led_next = '{red: 1'b1, green: 1'b0};
			default: led_next = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registers, frozen while clock enable is low

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= rhm_pkg::ST_INIT;
			pat_reg <= rhm_pkg::PAT_ORANGE;
			action_reg <= '0;
			led_reg <= '0;
			btn_prev_reg <= 1'b0;
			sw_prev_reg <= 1'b0;
			press_ms_reg <= '0;
			step_ms_reg <= '0;
			blink_ms_reg <= '0;
			blink_ph_reg <= 1'b1;
		end else if (clk_en) begin
			state_reg <= state_next;
			pat_reg <= pat_next;
			action_reg <= action_next;
			led_reg <= led_next;
			btn_prev_reg <= button_pressed;
			sw_prev_reg <= switch_run;
			press_ms_reg <= press_ms_next;
			step_ms_reg <= step_ms_next;
			blink_ms_reg <= blink_ms_next;
			blink_ph_reg <= blink_ph_next;
		end
	end

	// clock preset, loaded with its pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rtc_reg <= '0;
		end else if (clk_en && action_next.rtc_load) begin
			rtc_reg <= rhm_pkg::RTC_PRESET;
		end
	end

	// outputs
	assign mode_o = '{
		run: (state_reg == rhm_pkg::ST_RUN),
		halt: (state_reg == rhm_pkg::ST_HALT),
		stop: (state_reg == rhm_pkg::ST_STOP),
		boot: (state_reg == rhm_pkg::ST_BOOT)
	};
	assign led_o = led_reg;
	assign action_o = action_reg;
	assign rtc_o = rtc_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_startup_leaves;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt) |=> (state_reg != rhm_pkg::ST_STARTUP);
	endproperty
	a_startup_leaves: assert property (p_startup_leaves) else $error("start-up release ignored");

	property p_boot;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt && pat_reg == rhm_pkg::PAT_GREEN1) |=> mode_o.boot ##1 mode_o.boot;
	endproperty
	a_boot: assert property (p_boot) else $error("green release did not boot");

	property p_part_erase;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt && pat_reg == rhm_pkg::PAT_RED4)
			|=> (action_o.erase_media && !action_o.erase_flash_backup && mode_o.run);
	endproperty
	a_part_erase: assert property (p_part_erase) else $error("partial erase wrong");

	property p_rtc_preset;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt && pat_reg == rhm_pkg::PAT_RED4)
			|=> (action_o.rtc_load && rtc_o == rhm_pkg::RTC_PRESET);
	endproperty
	a_rtc_preset: assert property (p_rtc_preset) else $error("clock preset not loaded");

	property p_stop_start;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt && pat_reg == rhm_pkg::PAT_RED2)
			|=> (mode_o.stop && !mode_o.run && action_o == '0);
	endproperty
	a_stop_start: assert property (p_stop_start) else $error("slow red did not stop");

	property p_full_erase;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt && pat_reg == rhm_pkg::PAT_REDGREEN)
			|=> (action_o.erase_media && action_o.erase_flash_backup && action_o.skip_card_copy);
	endproperty
	a_full_erase: assert property (p_full_erase) else $error("full erase wrong");

	property p_normal;
		@(posedge mclk) disable iff (sys_rst)
		(in_start && release_evt && pat_reg == rhm_pkg::PAT_ORANGE)
			|=> (mode_o.run && action_o == '0);
	endproperty
	a_normal: assert property (p_normal) else $error("orange release not normal");

	property p_toggle;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == rhm_pkg::ST_RUN && release_evt && !sw_fall && !sw_rise
			&& press_ms_reg > rhm_pkg::HALF_MS && press_ms_reg < rhm_pkg::LONG_MS)
			|=> mode_o.halt;
	endproperty
	a_toggle: assert property (p_toggle) else $error("mid press did not halt");

	property p_reload;
		@(posedge mclk) disable iff (sys_rst)
		(in_op && release_evt && !sw_fall && !sw_rise && press_ms_reg > rhm_pkg::LONG_MS)
			|=> (action_o.reload_prog && $stable(state_reg));
	endproperty
	a_reload: assert property (p_reload) else $error("long press did not reload");

	property p_short;
		@(posedge mclk) disable iff (sys_rst)
		(in_op && release_evt && !sw_fall && !sw_rise && press_ms_reg <= rhm_pkg::HALF_MS)
			|=> ($stable(state_reg) && action_o == '0);
	endproperty
	a_short: assert property (p_short) else $error("short press changed mode");

	property p_sw_stop;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == rhm_pkg::ST_RUN && clk_en && switch_enable && sw_prev_reg && !switch_run)
			|=> mode_o.stop;
	endproperty
	a_sw_stop: assert property (p_sw_stop) else $error("switch did not stop");

	property p_sw_run;
		@(posedge mclk) disable iff (sys_rst)
		(in_op && clk_en && switch_enable && !sw_prev_reg && switch_run)
			|=> (action_o.cold_start && mode_o.run);
	endproperty
	a_sw_run: assert property (p_sw_run) else $error("switch did not cold start");

	property p_sw_off;
		@(posedge mclk) disable iff (sys_rst)
		(clk_en && !switch_enable) |=> !action_o.cold_start;
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("disabled switch acted");

	property p_step;
		@(posedge mclk) disable iff (sys_rst)
		(step_done && !release_evt) |=> (pat_reg != $past(pat_reg) && step_ms_reg == '0);
	endproperty
	a_step: assert property (p_step) else $error("pattern did not advance");

endmodule

// ===== core/rhm_pkg.sv
// rhm_pkg: shared types and constants of the run/halt mode controller
package rhm_pkg;

	// system clock rate and time base
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	// cycles in one millisecond, default of the top-level parameter
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

	// width of every millisecond counter
	localparam int MS_W = 12;

	// press windows in operation, milliseconds
	localparam logic [MS_W-1:0] HALF_MS = 12'h1f4;
	localparam logic [MS_W-1:0] LONG_MS = 12'hbb8;
	// press counter stops one past the long window
	localparam logic [MS_W-1:0] LONG_SAT = LONG_MS + 12'h001;

	// time each start-up pattern is shown, milliseconds
	localparam logic [MS_W-1:0] STEP_MS = 12'h7d0;
	localparam logic [MS_W-1:0] STEP_LAST = STEP_MS - 12'h001;

	// blink rates of the start-up patterns
	localparam int BLINK1_HZ = 1;
	localparam int BLINK2_HZ = 2;
	localparam int BLINK4_HZ = 4;
	// last count of each half period, milliseconds
	localparam logic [MS_W-1:0] BLINK1_LAST = MS_W'(MS_PER_S / (2 * BLINK1_HZ) - 1);
	localparam logic [MS_W-1:0] BLINK2_LAST = MS_W'(MS_PER_S / (2 * BLINK2_HZ) - 1);
	localparam logic [MS_W-1:0] BLINK4_LAST = MS_W'(MS_PER_S / (2 * BLINK4_HZ) - 1);

	// controller states
	typedef enum logic [2:0] {
		ST_INIT,
		ST_STARTUP,
		ST_BOOT,
		ST_RUN,
		ST_HALT,
		ST_STOP
	} rhm_state_t;

	// start-up led patterns in display order
	typedef enum logic [2:0] {
		PAT_ORANGE,
		PAT_GREEN1,
		PAT_RED4,
		PAT_RED2,
		PAT_REDGREEN
	} rhm_pat_t;

	// operating mode shown to the cpu
	typedef struct packed {
		logic run;
		logic halt;
		logic stop;
		logic boot;
	} rhm_mode_t;

	// one-cycle action requests
	typedef struct packed {
		logic cold_start;
		logic erase_media;
		logic erase_flash_backup;
		logic rtc_load;
		logic skip_card_copy;
		logic reload_prog;
	} rhm_action_t;

	// front led pair
	typedef struct packed {
		logic red;
		logic green;
	} rhm_led_t;

	// real-time clock preset value
	typedef struct packed {
		logic [11:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rhm_rtc_t;

	// midnight, first of january 1990
	localparam rhm_rtc_t RTC_PRESET = '{
		year: 12'h7c6,
		month: 4'h1,
		day: 5'h01,
		hour: 5'h00,
		minute: 6'h00,
		second: 6'h00
	};

endpackage

// ===== core/rhm_ms_tick.sv
// rhm_ms_tick: one-millisecond tick generator
`timescale 1ns/1ps
module rhm_ms_tick #(
	parameter int CYC_PER_MS = rhm_pkg::CYC_PER_MS
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	output logic ms_tick
);

	// counter width, at least one bit
	localparam int CNT_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
	// last count before the tick
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYC_PER_MS - 1);

	// cycle counter inside the millisecond
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	// end of the millisecond
	logic wrap;

	assign wrap = (cnt_reg == CNT_LAST);
	assign cnt_next = wrap ? '0 : cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
	// tick only on an enabled edge so it is never counted twice
	assign ms_tick = clk_en & wrap;

	// counter frozen while clock enable is low
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
		end
	end

endmodule

// ===== bench/rhm_operator.sv
// rhm_operator: behavioural front-panel operator for the run/halt button and switch
`timescale 1ns/1ps
module rhm_operator #(
	parameter int CYC_PER_MS = 4
) (
	input wire logic mclk,
	output logic button_pressed,
	output logic switch_run,
	output logic switch_enable
);

	// idle panel: button up, switch on run, switch not enabled
	initial begin
		button_pressed = 1'b0;
		switch_run = 1'b1;
		switch_enable = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// set the button level just after an edge and leave it there
	task automatic set_button(input logic lvl);
		@(posedge mclk);
		button_pressed <= lvl;
	endtask

	// press for a number of milliseconds, then let go
	task automatic press_ms(input int ms);
		set_button(1'b1);
		repeat (ms * CYC_PER_MS) @(posedge mclk);
		button_pressed <= 1'b0;
	endtask

	// move the switch and the configuration option together
	task automatic set_switch(input logic run, input logic en);
		@(posedge mclk);
		switch_run <= run;
		switch_enable <= en;
	endtask

endmodule

// ===== bench/tb_top.sv
// tb_top: self-checking bench of the run/halt mode controller
`timescale 1ns/1ps
module tb_top;

	// short millisecond so start-up patterns fit the run
	localparam int CPM = 2;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic button_pressed;
	logic switch_run;
	logic switch_enable;
	rhm_pkg::rhm_mode_t mode_o;
	rhm_pkg::rhm_led_t led_o;
	rhm_pkg::rhm_action_t action_o;
	rhm_pkg::rhm_rtc_t rtc_o;
	// sticky record of action pulses and its clear
	logic [5:0] act_seen = 6'h00;
	logic clr_seen = 1'b0;
	int err_count = 0;
	int num_checks = 0;
	int seed = 6981;
	int ms;

	always #10 mclk = ~mclk;

	// collect one-cycle pulses so none is missed between checks
	always @(posedge mclk) begin
		act_seen <= clr_seen ? 6'h00 : (act_seen | action_o);
	end

	rhm_mode_ctrl #(.CYC_PER_MS(CPM)) dut_u (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.button_pressed(button_pressed),
		.switch_run(switch_run),
		.switch_enable(switch_enable),
		.mode_o(mode_o),
		.led_o(led_o),
		.action_o(action_o),
		.rtc_o(rtc_o)
	);

	rhm_operator #(.CYC_PER_MS(CPM)) op_u (
		.mclk(mclk),
		.button_pressed(button_pressed),
		.switch_run(switch_run),
		.switch_enable(switch_enable)
	);

	////////////////////////////////////////////////////////////////////////////////
	// expected mode per pattern: {run,halt,stop,boot}
	function automatic logic [3:0] exp_mode(input int pat);
		case (pat)
			1: exp_mode = 4'h1;
			3: exp_mode = 4'h2;
			default: exp_mode = 4'h8;
		endcase
	endfunction

	// expected actions per pattern, cold_start in the top bit
	function automatic logic [5:0] exp_act(input int pat);
		case (pat)
			2: exp_act = 6'h14;
			4: exp_act = 6'h1a;
			default: exp_act = 6'h00;
		endcase
	endfunction

	// lit half of each pattern: {red,green}
	function automatic logic [1:0] exp_led(input int pat);
		case (pat)
			0: exp_led = 2'h3;
			1: exp_led = 2'h1;
			default: exp_led = 2'h2;
		endcase
	endfunction

	// clock preset only after the fast-red erase: 1990, month 1, day 1, midnight
	function automatic logic [37:0] exp_rtc(input int pat);
		exp_rtc = (pat == 2) ? {12'h7c6, 4'h1, 5'h01, 17'h00000} : 38'h0;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string name, input logic [37:0] exp, input logic [37:0] got);
		// look just after the edge, once the registers have settled
		#1;
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one pulse of the clear
	task automatic clear_seen();
		@(posedge mclk);
		clr_seen <= 1'b1;
		@(posedge mclk);
		clr_seen <= 1'b0;
	endtask

	// reset for eleven cycles with the button strap already set
	task automatic do_reset(input logic btn);
		@(posedge mclk);
		sys_rst <= 1'b1;
		op_u.set_button(btn);
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		clear_seen();
	endtask

	// mode and pulses a few cycles after a stimulus
	task automatic chk_result(input logic [3:0] em, input logic [5:0] ea);
		repeat (4) @(posedge mclk);
		chk("mode", 38'(em), 38'(mode_o));
		chk("action", 38'(ea), 38'(act_seen));
	endtask

	// power up with the button held, release inside one pattern
	task automatic startup(input int pat, input int rel_ms);
		do_reset(1'b1);
		repeat (rel_ms * CPM) @(posedge mclk);
		if (pat == 4) begin
			chk("led_alt", 38'h1, 38'(led_o.red ^ led_o.green));
		end else begin
			chk("led", 38'(exp_led(pat)), 38'(led_o));
		end
		op_u.set_button(1'b0);
		chk_result(exp_mode(pat), exp_act(pat));
		chk("rtc", exp_rtc(pat), 38'(rtc_o));
		$display("test startup pattern %0d done", pat);
	endtask

	// press in operation and check the outcome
	task automatic op_press(input int len, input logic [3:0] em, input logic [5:0] ea);
		clear_seen();
		op_u.press_ms(len);
		chk_result(em, ea);
		$display("test press %0d ms done", len);
	endtask

	// move the switch and check the outcome
	task automatic sw(input logic run, input logic en, input logic [3:0] em,
		input logic [5:0] ea);
		clear_seen();
		op_u.set_switch(run, en);
		chk_result(em, ea);
		$display("test switch run %0d enable %0d done", run, en);
	endtask

	// clock enable low holds off a switch move until it returns
	task automatic freeze_test();
		clear_seen();
		@(posedge mclk);
		clk_en <= 1'b0;
		op_u.set_switch(1'b0, 1'b1);
		repeat (8) @(posedge mclk);
		chk("frozen_mode", 38'h8, 38'(mode_o));
		@(posedge mclk);
		clk_en <= 1'b1;
		chk_result(4'h2, 6'h00);
		$display("test clock enable freeze done");
	endtask

	// print counts and the verdict, then stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// hang guard
	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		$display("test timeout");
		give_verdict();
	end

	// main sequence
	initial begin
		do_reset(1'b0);
		sw(1'b0, 1'b0, 4'h8, 6'h00);
		sw(1'b1, 1'b0, 4'h8, 6'h00);
		sw(1'b1, 1'b1, 4'h8, 6'h00);
		sw(1'b0, 1'b1, 4'h2, 6'h00);
		sw(1'b1, 1'b1, 4'h8, 6'h20);
		startup(1, 2020);
		startup(2, 4020);
		startup(3, 6020);
		startup(4, 8020);
		startup(0, 100);
		ms = 10 + ($unsigned($random(seed)) % 290);
		op_press(ms, 4'h8, 6'h00);
		ms = 520 + ($unsigned($random(seed)) % 180);
		op_press(ms, 4'h4, 6'h00);
		ms = 520 + ($unsigned($random(seed)) % 180);
		op_press(ms, 4'h8, 6'h00);
		op_press(3050, 4'h8, 6'h01);
		// switch move held off by clock enable
		freeze_test();
		give_verdict();
	end

endmodule
